// ===== include/iqs_pkg.sv
// constants, field layout and carrier types of the status flags and interrupt controller
// assumes a single system clock shared by core, timers and link engine
//
// Operation
// - software writes to status change arithmetic flags, never powerdown or timeout flags
// - watchdog timeout sets status bit 5; power-up, kick or halt clear it
// - halt sets status bit 4; power-up or watchdog kick clear it
// - bit 0 is add carry or subtract no-borrow; rotate through carry updates it
// - bit 1 is low nibble carry, or no borrow into low nibble
// - bit 2 is set when an arithmetic or logic result is zero
// - bit 3 is carry into msb differing from carry out of msb
// - status bits 6 and 7 and control bit 7 read zero
// - interrupt entry pushes only the program counter, never the status
// - entering service clears global enable; new requests still latch pending
// - no interrupt acknowledge while stack is full; held until stack pops
// - enabled link pending in bit 4 vectors to 04H, clears flag and enable
// - host fifo access sets its flag bit and link interrupt; firmware clears
// - bus suspend sets link event bit 0 and raises link interrupt
// - resume sets link event bit 3 and raises link interrupt
// - bus reset sets bus reset seen bit, raises link interrupt; firmware clears
// - timer 0 overflow sets bit 5; when enabled vectors 08H, clears flag, enable
// - timer 1 overflow sets bit 6; when enabled vectors 0CH, clears flag, enable
// - control bits 0 to 3: global, link, timer 0, timer 1 enables
// - return from interrupt sets global enable; plain return leaves it
// - requests between sample pulse rising edges are served at the later edge
// - simultaneous requests: link first, then timer 0, then timer 1
package iqs_pkg;
  localparam int IQS_AW = 10;
  localparam logic [7:0] IQS_IDX_STATUS = 8'h0A;
  localparam logic [7:0] IQS_IDX_IRQ_CONTROL_REG = 8'h0B;
  localparam logic [7:0] IQS_IDX_USC = 8'h1A;
  localparam logic [7:0] IQS_IDX_USR = 8'h1B;
  localparam int IQS_ST_C = 0;
  localparam int IQS_ST_AC = 1;
  localparam int IQS_ST_Z = 2;
  localparam int IQS_ST_OV = 3;
  localparam int IQS_ST_PDF = 4;
  localparam int IQS_ST_TO = 5;
  localparam int IQS_IC_GIE = 0;
  localparam int IQS_IC_EN_LO = 1;
  localparam int IQS_IC_PEND_LO = 4;
  localparam int IQS_IC_PEND_HI = 6;
  localparam int IQS_LE_SUSP = 0;
  localparam int IQS_LE_BRST = 2;
  localparam int IQS_LE_RES = 3;
  localparam logic [7:0] IQS_STATUS_RST = 8'h00;
  localparam logic [7:0] IQS_IRQ_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] IQS_USC_RST = 8'h00;
  localparam logic [7:0] IQS_IRQ_CONTROL_REG_MASK = 8'h7F;
  localparam logic [7:0] IQS_USC_MASK = 8'h0D;
  localparam logic [7:0] IQS_VEC_LINK = 8'h04;
  localparam logic [7:0] IQS_VEC_T0 = 8'h08;
  localparam logic [7:0] IQS_VEC_T1 = 8'h0C;
  typedef enum logic [2:0] {
    IQS_ALU_NONE, IQS_ALU_ADD, IQS_ALU_SUB, IQS_ALU_LOGIC, IQS_ALU_RLC, IQS_ALU_RRC
  } iqs_alu_kind_t;
  typedef struct packed {
    logic valid;
    iqs_alu_kind_t kind;
    logic [7:0] a;
    logic [7:0] b;
    logic cin;
  } iqs_alu_req_t;
  typedef struct packed {
    logic suspend;
    logic resume;
    logic bus_reset;
  } iqs_link_evt_t;
  typedef struct packed {
    logic take;
    logic push_pc;
    logic [7:0] vector;
  } iqs_irq_ack_t;
endpackage

// ===== logic/iqs_irq_and_status_flags.sv
// status flag register and three-source interrupt controller
// assumes all inputs come from logic on clk; registers reached over classic wishbone
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module iqs_irq_and_status_flags #(
  parameter int NUM_FIFO = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [iqs_pkg::IQS_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core sequencer
  input wire iqs_pkg::iqs_alu_req_t alu_req,
  input wire logic halt_exec,
  input wire logic watchdog_kick_instr,
  input wire logic return_from_irq_instr,
  input wire logic stack_full,
  input wire logic sample_phase_pulse,
  output iqs_pkg::iqs_irq_ack_t irq_ack,
  output logic [7:0] status_flags,
  output logic [7:0] irq_control_reg,
  // watchdog and timers
  input wire logic wdt_timeout,
  input wire logic timer0_ovf,
  input wire logic timer1_ovf,
  // link engine
  input wire logic [NUM_FIFO-1:0] fifo_access,
  input wire iqs_pkg::iqs_link_evt_t link_evt
);
  import iqs_pkg::*;

  if (NUM_FIFO < 1 || NUM_FIFO > 8) begin : g_bad_fifo
    $error("NUM_FIFO must be 1 to 8");
  end

  logic [7:0] status_r;
  logic [7:0] irq_control_reg_r;
  logic [7:0] irq_control_reg_nxt;
  logic [7:0] usc_r;
  logic [7:0] usc_nxt;
  logic [NUM_FIFO-1:0] usr_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic phase_q_r;
  iqs_irq_ack_t irq_ack_r;

  // bus decode
  logic bus_req;
  logic wr_lo;
  logic [7:0] idx;
  logic wr_status;
  logic wr_irq_control_reg;
  logic wr_usc;
  logic wr_usr;
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_lo = bus_req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[IQS_AW-1:2];
  assign wr_status = wr_lo && (idx == IQS_IDX_STATUS);
  assign wr_irq_control_reg = wr_lo && (idx == IQS_IDX_IRQ_CONTROL_REG);
  assign wr_usc = wr_lo && (idx == IQS_IDX_USC);
  assign wr_usr = wr_lo && (idx == IQS_IDX_USR);

  // alu flag arithmetic; subtract is a plus not-b plus carry-in
  logic [7:0] opb;
  logic [8:0] sum9;
  logic [4:0] lo5;
  logic c_into_msb;
  logic ovf;
  always_comb begin
    opb = (alu_req.kind == IQS_ALU_SUB) ? ~alu_req.b : alu_req.b;
    sum9 = {1'b0, alu_req.a} + {1'b0, opb} + {8'h00, alu_req.cin};
    lo5 = {1'b0, alu_req.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, alu_req.cin};
    c_into_msb = alu_req.a[7] ^ opb[7] ^ sum9[7];
    ovf = c_into_msb ^ sum9[8];
  end

  // status register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= IQS_STATUS_RST;
    end else begin
      if (wr_status) begin
        status_r[IQS_ST_OV:IQS_ST_C] <= wb_dat_i[IQS_ST_OV:IQS_ST_C];
      end
      if (alu_req.valid) begin
        case (alu_req.kind)
          IQS_ALU_ADD, IQS_ALU_SUB: begin
            status_r[IQS_ST_C] <= sum9[8];
            status_r[IQS_ST_AC] <= lo5[4];
            status_r[IQS_ST_Z] <= (sum9[7:0] == 8'h00);
            status_r[IQS_ST_OV] <= ovf;
          end
          IQS_ALU_LOGIC: status_r[IQS_ST_Z] <= (alu_req.a == 8'h00);
          IQS_ALU_RLC: status_r[IQS_ST_C] <= alu_req.a[7];
          IQS_ALU_RRC: status_r[IQS_ST_C] <= alu_req.a[0];
          default: ;
        endcase
      end
      if (watchdog_kick_instr) begin
        status_r[IQS_ST_PDF] <= 1'b0;
        status_r[IQS_ST_TO] <= 1'b0;
      end
      if (halt_exec) begin
        status_r[IQS_ST_PDF] <= 1'b1;
        status_r[IQS_ST_TO] <= 1'b0;
      end
      // timeout wins over a same-cycle clear so the event is not lost
      if (wdt_timeout) begin
        status_r[IQS_ST_TO] <= 1'b1;
      end
    end
  end

  // request sampling and priority
  logic phase_rise;
  logic link_any;
  logic [2:0] set_pend;
  logic [2:0] req;
  logic [2:0] pick;
  logic take;
  assign phase_rise = sample_phase_pulse & ~phase_q_r;
  assign link_any = (|fifo_access) | link_evt.suspend | link_evt.resume
    | link_evt.bus_reset;
  assign set_pend = {timer1_ovf, timer0_ovf, link_any};
  assign req = irq_control_reg_r[IQS_IC_PEND_HI:IQS_IC_PEND_LO]
    & irq_control_reg_r[IQS_IC_EN_LO+2:IQS_IC_EN_LO];
  assign pick = {req[2] & ~req[1] & ~req[0], req[1] & ~req[0], req[0]};
  // full stack holds the acknowledge; the pending flag stays for later
  assign take = phase_rise & irq_control_reg_r[IQS_IC_GIE] & ~stack_full & (|req);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q_r <= 1'b0;
    end else begin
      phase_q_r <= sample_phase_pulse;
    end
  end

  // control register next value; hardware sets applied last so they win
  always_comb begin
    irq_control_reg_nxt = irq_control_reg_r;
    if (wr_irq_control_reg) begin
      irq_control_reg_nxt = wb_dat_i[7:0] & IQS_IRQ_CONTROL_REG_MASK;
    end
    if (return_from_irq_instr) begin
      irq_control_reg_nxt[IQS_IC_GIE] = 1'b1;
    end
    if (take) begin
      irq_control_reg_nxt[IQS_IC_GIE] = 1'b0;
      irq_control_reg_nxt[IQS_IC_PEND_HI:IQS_IC_PEND_LO] =
        irq_control_reg_nxt[IQS_IC_PEND_HI:IQS_IC_PEND_LO] & ~pick;
    end
    irq_control_reg_nxt[IQS_IC_PEND_HI:IQS_IC_PEND_LO] =
      irq_control_reg_nxt[IQS_IC_PEND_HI:IQS_IC_PEND_LO] | set_pend;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_control_reg_r <= IQS_IRQ_CONTROL_REG_RST;
    end else begin
      irq_control_reg_r <= irq_control_reg_nxt;
    end
  end

  // acknowledge to the sequencer; only the program counter is pushed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack_r <= '0;
    end else begin
      irq_ack_r.take <= take;
      irq_ack_r.push_pc <= take;
      if (take) begin
        irq_ack_r.vector <= pick[0] ? IQS_VEC_LINK
          : (pick[1] ? IQS_VEC_T0 : IQS_VEC_T1);
      end
    end
  end

  // link event register
  always_comb begin
    usc_nxt = usc_r;
    if (wr_usc) begin
      usc_nxt = wb_dat_i[7:0] & IQS_USC_MASK;
    end
    if (link_evt.suspend) begin
      usc_nxt[IQS_LE_SUSP] = 1'b1;
    end
    if (link_evt.resume) begin
      usc_nxt[IQS_LE_RES] = 1'b1;
    end
    if (link_evt.bus_reset) begin
      usc_nxt[IQS_LE_BRST] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      usc_r <= IQS_USC_RST;
    end else begin
      usc_r <= usc_nxt;
    end
  end

  // fifo access flags, one per endpoint fifo
  for (genvar i = 0; i < NUM_FIFO; i++) begin : g_usr
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        usr_r[i] <= 1'b0;
      end else if (fifo_access[i]) begin
        usr_r[i] <= 1'b1;
      end else if (wr_usr) begin
        usr_r[i] <= wb_dat_i[i];
      end
    end
  end

  // bus answer: one wait cycle, unmapped reads zero, writes dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_req) begin
        case (idx)
          IQS_IDX_STATUS: rdat_r <= {24'h00_0000, 2'b00, status_r[5:0]};
          IQS_IDX_IRQ_CONTROL_REG: rdat_r <= {24'h00_0000, 1'b0, irq_control_reg_r[6:0]};
          IQS_IDX_USC: rdat_r <= {24'h00_0000, usc_r};
          IQS_IDX_USR: rdat_r <= {{(32-NUM_FIFO){1'b0}}, usr_r};
          default: rdat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq_ack = irq_ack_r;
  assign status_flags = status_r;
  assign irq_control_reg = irq_control_reg_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_SW_KEEPS_PWR: assert property (
    wr_status && !halt_exec && !watchdog_kick_instr && !wdt_timeout
    |=> status_r[5:4] == $past(status_r[5:4]))
    else $error("status write changed powerdown or timeout flag");
  AST_TO_SET: assert property (
    wdt_timeout |=> status_r[IQS_ST_TO])
    else $error("timeout flag not set");
  AST_HALT_FLAGS: assert property (
    halt_exec && !wdt_timeout |=> status_r[IQS_ST_PDF] && !status_r[IQS_ST_TO])
    else $error("halt did not set powerdown and clear timeout");
  AST_ADD_CARRY: assert property (
    alu_req.valid && alu_req.kind == IQS_ALU_ADD && alu_req.a == 8'hFF
    && alu_req.b == 8'h01 && alu_req.cin == 1'b0
    |=> status_r[3:0] == 4'h7)
    else $error("add carry, half carry or zero wrong");
  AST_ZERO_FLAG: assert property (
    alu_req.valid && alu_req.kind == IQS_ALU_LOGIC
    |=> status_r[IQS_ST_Z] == ($past(alu_req.a) == 8'h00))
    else $error("zero flag wrong after logic op");
  AST_UNUSED_ZERO: assert property (
    wb_ack_o |-> (idx != IQS_IDX_STATUS || wb_dat_o[7:6] == 2'b00)
    && (idx != IQS_IDX_IRQ_CONTROL_REG || !wb_dat_o[7]))
    else $error("unused bits read nonzero");
  AST_TAKE_GIE: assert property (
    take |=> irq_ack.take && !irq_control_reg[IQS_IC_GIE] ##1 !irq_ack.take)
    else $error("service entry did not clear global enable");
  AST_FULL_HOLD: assert property (
    stack_full |=> !irq_ack.take)
    else $error("acknowledge while stack full");
  AST_LINK_FIRST: assert property (
    take && req[0] |=> irq_ack.vector == IQS_VEC_LINK && !irq_control_reg_r[IQS_IC_PEND_LO + 0]
    || $past(set_pend[0]))
    else $error("link request not served first");
  AST_RETURN_FROM_IRQ_INSTR_GIE: assert property (
    return_from_irq_instr && !take |=> irq_control_reg_r[IQS_IC_GIE])
    else $error("return from interrupt left enable clear");
  AST_SUSPEND: assert property (
    link_evt.suspend |=> usc_r[IQS_LE_SUSP] && irq_control_reg_r[IQS_IC_PEND_LO])
    else $error("suspend not latched");
  AST_SAMPLE_EDGE: assert property (
    !phase_rise |=> !irq_ack.take)
    else $error("acknowledge away from sample edge");

  COV_LINK_TAKE: cover property (take && pick[0]);
  COV_T1_TAKE: cover property (take && pick[2]);
  COV_FULL_BLOCK: cover property (phase_rise && irq_control_reg_r[IQS_IC_GIE] && |req && stack_full);
  COV_RETURN_FROM_IRQ_INSTR: cover property (return_from_irq_instr ##1 take);
endmodule // iqs_irq_and_status_flags
`default_nettype wire

// ===== verification/iqs_core_model.sv
// core partner: program stack depth and sample phase pulse
// assumes irq_ack and return pulses from the controller on clk
`timescale 1ns/1ps
`default_nettype none
module iqs_core_model #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller side
  input wire iqs_pkg::iqs_irq_ack_t irq_ack,
  input wire logic return_from_irq_instr,
  output logic stack_full,
  output logic sample_phase_pulse
);
  import iqs_pkg::*;
  logic [3:0] depth_r;
  logic [1:0] ph_r;
  logic pop;
  assign pop = return_from_irq_instr && depth_r != 4'h0;
  // pc only, status never saved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_r <= 4'h0;
    end else begin
      depth_r <= depth_r + {3'h0, irq_ack.push_pc} - {3'h0, pop};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // small depth so a full stack is reached quickly
  assign stack_full = depth_r == 4'(DEPTH);
  assign sample_phase_pulse = ph_r[1];
endmodule // iqs_core_model
`default_nettype wire

// ===== verification/irq_and_status_flags_tb.sv
// self-checking bench of the status flags and interrupt controller
// assumes iqs_pkg and iqs_core_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module irq_and_status_flags_tb;
  import iqs_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [IQS_AW-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack;
  iqs_alu_req_t alu = '0;
  logic [12:0] ev_r = '0;
  logic full;
  logic phase;
  iqs_irq_ack_t iack;
  logic [7:0] st;
  logic [7:0] ic;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h45;
  logic [31:0] rv;
  logic [3:0] ef = 4'h0;
  logic [7:0] exp_q[$];
  int s, l, m, bb, k;
  logic [9:0] adrs[5] = '{10'h028, 10'h02C, 10'h068, 10'h06C, 10'h3FC};
  logic [12:0] sev[5] = '{13'h001, 13'h008, 13'h001, 13'h008, 13'h002};
  logic [31:0] sexp[5] = '{32'h1F, 32'h3F, 32'h1F, 32'h3F, 32'h0F};
  iqs_irq_and_status_flags dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .alu_req(alu), .halt_exec(ev_r[0]), .watchdog_kick_instr(ev_r[1]),
    .return_from_irq_instr(ev_r[2]), .stack_full(full), .sample_phase_pulse(phase),
    .irq_ack(iack), .status_flags(st), .irq_control_reg(ic), .wdt_timeout(ev_r[3]),
    .timer0_ovf(ev_r[4]), .timer1_ovf(ev_r[5]), .fifo_access(ev_r[12:9]),
    .link_evt(iqs_link_evt_t'(ev_r[8:6])));
  iqs_core_model #(.DEPTH(2)) core (.clk(clk), .rst_n(rst_n), .irq_ack(iack),
    .return_from_irq_instr(ev_r[2]), .stack_full(full), .sample_phase_pulse(phase));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // waits on ack, bounded so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, rv);
    chk(rv, e);
  endtask
  task automatic pulse(input logic [12:0] p);
    @(posedge clk);
    ev_r <= p;
    @(posedge clk);
    ev_r <= '0;
    #1;
  endtask
  task automatic alu_op(input int kd, input logic [7:0] a, input logic [7:0] b, input logic c);
    @(posedge clk);
    alu <= '{1'b1, iqs_alu_kind_t'(3'(kd)), a, b, c};
    @(posedge clk);
    alu <= '0;
    bb = (kd == 2) ? (~b & 8'hFF) : b;
    s = a + bb + c;
    l = (a & 15) + (bb & 15) + c;
    m = (a & 127) + (bb & 127) + c;
    if (kd <= 2) begin
      ef = {m[7] ^ s[8], s[7:0] == 0, l[4], s[8]};
    end
    if (kd == 3) ef[2] = (a == 8'h00);
    if (kd == 4) ef[0] = a[7];
    if (kd == 5) ef[0] = a[0];
    #1;
    chk({24'h0, st}, {28'h0, ef});
  endtask
  task automatic take;
    int n;
    n = 0;
    // settle first: the acknowledge may launch at the edge the bus task returned on
    #1;
    while (iack.take !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, iack.take}, 1);
    chk({24'h0, iack.vector}, {24'h0, exp_q.pop_front()});
    chk({31'h0, ic[IQS_IC_GIE]}, 0);
    @(posedge clk);
  endtask
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b1, 10'h3FC, 32'hFF, rv);
    foreach (adrs[i]) rchk(adrs[i], 0);
    $display("test 1 done");
    wb(1'b1, 10'h028, 32'hFF, rv);
    rchk(10'h028, 32'h0F);
    foreach (sev[i]) begin
      pulse(sev[i]);
      chk({24'h0, st}, sexp[i]);
    end
    pulse(13'h001);
    wb(1'b1, 10'h028, 32'h0, rv);
    rchk(10'h028, 32'h10);
    pulse(13'h002);
    chk({24'h0, st}, 32'h0);
    $display("test 2 done");
    alu_op(1, 8'h80, 8'h80, 1'b0);
    alu_op(2, 8'h10, 8'h01, 1'b1);
    for (k = 0; k < 60; k++) begin
      seed = xs(seed);
      alu_op(seed % 5 + 1, seed[15:8], seed[23:16], seed[24]);
    end
    $display("test 3 done");
    pulse(13'h0800);
    pulse(13'h0100);
    pulse(13'h0080);
    pulse(13'h0040);
    rchk(10'h068, 32'h0D);
    rchk(10'h06C, 32'h04);
    rchk(10'h02C, 32'h10);
    wb(1'b1, 10'h068, 32'h0, rv);
    rchk(10'h068, 32'h0);
    wb(1'b1, 10'h06C, 32'h0, rv);
    rchk(10'h06C, 32'h0);
    $display("test 4 done");
    pulse(13'h030);
    exp_q = '{8'h04, 8'h08, 8'h0C};
    wb(1'b1, 10'h02C, 32'h7F, rv);
    take();
    rchk(10'h02C, 32'h6E);
    wb(1'b1, 10'h02C, 32'h6F, rv);
    take();
    wb(1'b1, 10'h02C, 32'h4F, rv);
    repeat (20) begin
      @(posedge clk);
      #1;
      chk({31'h0, iack.take}, 0);
    end
    rchk(10'h02C, 32'h4F);
    pulse(13'h004);
    take();
    rchk(10'h02C, 32'h0E);
    pulse(13'h004);
    rchk(10'h02C, 32'h0F);
    $display("test 5 done");
    end_of_test();
  end
endmodule // irq_and_status_flags_tb
`default_nettype wire
